// file: hdl/qsm_defines.vh
// qsm_defines.vh: offsets, field positions and reset values of the queued serial master
// assumes inclusion by bare name from the design files under hdl/
`ifndef QSM_DEFINES_VH
`define QSM_DEFINES_VH
// register indices (word address on the plain port)
`define QSM_ADDR_W        4
`define QSM_A_CTRL        4'h0
`define QSM_A_CS_POL      4'h1
`define QSM_A_CS_SEL      4'h2
`define QSM_A_DELAY       4'h3
`define QSM_A_PIN_EN      4'h4
`define QSM_A_GPIO_OUT    4'h5
`define QSM_A_GPIO_OE     4'h6
`define QSM_A_GPIO_IN     4'h7
`define QSM_A_QADDR       4'h8
`define QSM_A_QDATA       4'h9
`define QSM_A_START       4'hA
`define QSM_A_STATUS      4'hB
`define QSM_A_DIV         4'hC
// control fields
`define QSM_CTRL_CPOL     0
`define QSM_CTRL_CPHA     1
`define QSM_CTRL_LSB      2
`define QSM_CTRL_SAMP_FALL 3
// pin bit positions: 0..4 selects, 5 clock, 6 mosi, 7 miso
`define QSM_NPIN          8
`define QSM_PIN_SCK       5
`define QSM_PIN_MOSI      6
`define QSM_PIN_MISO      7
// reset values
`define QSM_CTRL_RST      4'h0
`define QSM_CS_POL_RST    5'h00
`define QSM_DELAY_RST     8'h01
`define QSM_DIV_RST       8'h04
`define QSM_PIN_RST       8'h00
// status bits
`define QSM_ST_BUSY       0
`endif

// file: hdl/qsm_sync2.v
// qsm_sync2.v: two flip-flop synchroniser for one bit
// assumes the input comes from outside the sys_clk domain
`timescale 1ns/10ps
module qsm_sync2 (
  // clock and reset
  input  wire sys_clk,
  input  wire reset_n,
  // data
  input  wire d_async,
  output wire q_sync
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_async;
      sync_reg <= meta_reg;
    end
  end
  assign q_sync = sync_reg;
endmodule // qsm_sync2

// file: hdl/qsm_pad.v
// qsm_pad.v: one port pin muxed between the serial function and general-purpose i/o
// assumes the pad itself resolves level from out/oe and owns a switchable pull resistor
`timescale 1ns/10ps
module qsm_pad (
  // function side
  input  wire func_en,
  input  wire func_out,
  input  wire func_oe,
  // general-purpose side
  input  wire gp_out,
  input  wire gp_oe,
  // pad side
  output wire pad_out,
  output wire pad_oe,
  output wire pad_pull_en
);
  assign pad_out     = func_en ? func_out : gp_out;
  assign pad_oe      = func_en ? func_oe  : gp_oe;
  assign pad_pull_en = ~pad_oe;
endmodule // qsm_pad

// file: hdl/qsm_master.v
// qsm_master.v: queued serial master with five selects and gpio fallback pins
// assumes register port on sys_clk; peripherals hang on the pads outside
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
`include "qsm_defines.vh"
module qsm_master #(
  parameter DEPTH  = 16,
  parameter QAW    = 4,
  parameter NBITS  = 8
) (
  // clock and reset
  input  wire                   sys_clk,
  input  wire                   reset_n,
  // register port
  input  wire [`QSM_ADDR_W-1:0] reg_addr,
  input  wire [31:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [31:0]            reg_rdata,
  // pins: 0..4 selects, 5 clock, 6 mosi, 7 miso
  input  wire [`QSM_NPIN-1:0]   pin_in,
  output wire [`QSM_NPIN-1:0]   pin_out,
  output wire [`QSM_NPIN-1:0]   pin_oe,
  output wire [`QSM_NPIN-1:0]   pin_pull_en
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_LEAD  = 2'h1;
  localparam ST_SHIFT = 2'h2;
  localparam ST_TAIL  = 2'h3;

  reg  [3:0]         ctrl_reg;
  reg  [4:0]         cs_pol_reg;
  reg  [2:0]         cs_sel_reg;
  reg  [7:0]         delay_reg;
  reg  [7:0]         div_reg;
  reg  [7:0]         pin_en_reg;
  reg  [7:0]         gp_out_reg;
  reg  [7:0]         gp_oe_reg;
  reg  [QAW-1:0]     qaddr_reg;
  reg  [NBITS-1:0]   queue_mem [0:DEPTH-1];
  reg  [1:0]         state_reg;
  reg  [7:0]         cnt_reg;
  reg  [7:0]         div_cnt_reg;
  reg  [3:0]         bit_reg;
  reg                half_reg;
  reg  [NBITS-1:0]   tx_reg;
  reg  [NBITS-1:0]   rx_reg;
  reg  [QAW-1:0]     xfer_addr_reg;
  reg                sck_reg;
  reg                mosi_reg;
  reg  [4:0]         cs_out_reg;

  wire [`QSM_NPIN-1:0] pin_sync;
  wire                 cpol     = ctrl_reg[`QSM_CTRL_CPOL];
  wire                 cpha     = ctrl_reg[`QSM_CTRL_CPHA];
  wire                 lsb_first = ctrl_reg[`QSM_CTRL_LSB];
  wire                 samp_fall = ctrl_reg[`QSM_CTRL_SAMP_FALL];
  wire                 busy     = (state_reg != ST_IDLE);
  wire                 miso_s   = pin_sync[`QSM_PIN_MISO];
  wire                 tick     = (div_cnt_reg == 8'h00);
  wire [NBITS-1:0]     rx_shift = lsb_first ? {miso_s, rx_reg[NBITS-1:1]}
                                            : {rx_reg[NBITS-2:0], miso_s};
  wire [NBITS-1:0]     tx_shift = lsb_first ? {1'b0, tx_reg[NBITS-1:1]}
                                            : {tx_reg[NBITS-2:0], 1'b0};
  wire                 tx_bit   = lsb_first ? tx_reg[0] : tx_reg[NBITS-1];
  wire                 sck_next = ~sck_reg;
  // the edge about to happen is a sampling edge when it matches the set direction
  wire                 samp_edge = samp_fall ? (sck_reg & ~sck_next) : (~sck_reg & sck_next);

  genvar gi;
  generate
    for (gi = 0; gi < `QSM_NPIN; gi = gi + 1) begin : g_pin
      qsm_sync2 u_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .d_async (pin_in[gi]),
        .q_sync  (pin_sync[gi])
      );
    end
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_cs
      qsm_pad u_pad (
        .func_en     (pin_en_reg[gi]),
        .func_out    (cs_out_reg[gi]),
        .func_oe     (1'b1),
        .gp_out      (gp_out_reg[gi]),
        .gp_oe       (gp_oe_reg[gi]),
        .pad_out     (pin_out[gi]),
        .pad_oe      (pin_oe[gi]),
        .pad_pull_en (pin_pull_en[gi])
      );
    end
  endgenerate

  qsm_pad u_pad_sck (
    .func_en     (pin_en_reg[`QSM_PIN_SCK]),
    .func_out    (sck_reg),
    .func_oe     (1'b1),
    .gp_out      (gp_out_reg[`QSM_PIN_SCK]),
    .gp_oe       (gp_oe_reg[`QSM_PIN_SCK]),
    .pad_out     (pin_out[`QSM_PIN_SCK]),
    .pad_oe      (pin_oe[`QSM_PIN_SCK]),
    .pad_pull_en (pin_pull_en[`QSM_PIN_SCK])
  );
  qsm_pad u_pad_mosi (
    .func_en     (pin_en_reg[`QSM_PIN_MOSI]),
    .func_out    (mosi_reg),
    .func_oe     (1'b1),
    .gp_out      (gp_out_reg[`QSM_PIN_MOSI]),
    .gp_oe       (gp_oe_reg[`QSM_PIN_MOSI]),
    .pad_out     (pin_out[`QSM_PIN_MOSI]),
    .pad_oe      (pin_oe[`QSM_PIN_MOSI]),
    .pad_pull_en (pin_pull_en[`QSM_PIN_MOSI])
  );
  // miso is an input when used as the serial function
  qsm_pad u_pad_miso (
    .func_en     (pin_en_reg[`QSM_PIN_MISO]),
    .func_out    (1'b0),
    .func_oe     (1'b0),
    .gp_out      (gp_out_reg[`QSM_PIN_MISO]),
    .gp_oe       (gp_oe_reg[`QSM_PIN_MISO]),
    .pad_out     (pin_out[`QSM_PIN_MISO]),
    .pad_oe      (pin_oe[`QSM_PIN_MISO]),
    .pad_pull_en (pin_pull_en[`QSM_PIN_MISO])
  );

  // configuration registers
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_reg   <= `QSM_CTRL_RST;
      cs_pol_reg <= `QSM_CS_POL_RST;
      cs_sel_reg <= 3'h0;
      delay_reg  <= `QSM_DELAY_RST;
      div_reg    <= `QSM_DIV_RST;
      pin_en_reg <= `QSM_PIN_RST;
      gp_out_reg <= `QSM_PIN_RST;
      gp_oe_reg  <= `QSM_PIN_RST;
      qaddr_reg  <= {QAW{1'b0}};
    end else if (reg_wr) begin
      case (reg_addr)
        `QSM_A_CTRL:     ctrl_reg   <= reg_wdata[3:0];
        `QSM_A_CS_POL:   cs_pol_reg <= reg_wdata[4:0];
        `QSM_A_CS_SEL:   cs_sel_reg <= reg_wdata[2:0];
        `QSM_A_DELAY:    delay_reg  <= reg_wdata[7:0];
        `QSM_A_DIV:      div_reg    <= reg_wdata[7:0];
        `QSM_A_PIN_EN:   pin_en_reg <= reg_wdata[7:0];
        `QSM_A_GPIO_OUT: gp_out_reg <= reg_wdata[7:0];
        `QSM_A_GPIO_OE:  gp_oe_reg  <= reg_wdata[7:0];
        `QSM_A_QADDR:    qaddr_reg  <= reg_wdata[QAW-1:0];
        default: begin
        end
      endcase
    end
  end

  // queue memory: software writes and the shifter's received bytes
  always @(posedge sys_clk) begin
    if (reg_wr && reg_addr == `QSM_A_QDATA && !busy) begin
      queue_mem[qaddr_reg] <= reg_wdata[NBITS-1:0];
    end else if (state_reg == ST_TAIL && tick) begin
      queue_mem[xfer_addr_reg] <= rx_reg;
    end
  end

  // read port: data one cycle after the strobe
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `QSM_A_CTRL:     reg_rdata <= {28'h0, ctrl_reg};
        `QSM_A_CS_POL:   reg_rdata <= {27'h0, cs_pol_reg};
        `QSM_A_CS_SEL:   reg_rdata <= {29'h0, cs_sel_reg};
        `QSM_A_DELAY:    reg_rdata <= {24'h0, delay_reg};
        `QSM_A_DIV:      reg_rdata <= {24'h0, div_reg};
        `QSM_A_PIN_EN:   reg_rdata <= {24'h0, pin_en_reg};
        `QSM_A_GPIO_OUT: reg_rdata <= {24'h0, gp_out_reg};
        `QSM_A_GPIO_OE:  reg_rdata <= {24'h0, gp_oe_reg};
        `QSM_A_GPIO_IN:  reg_rdata <= {24'h0, pin_sync};
        `QSM_A_QADDR:    reg_rdata <= {{(32-QAW){1'b0}}, qaddr_reg};
        `QSM_A_QDATA:    reg_rdata <= {{(32-NBITS){1'b0}}, queue_mem[qaddr_reg]};
        `QSM_A_STATUS:   reg_rdata <= {31'h0, busy};
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // transfer engine: one word from the queue slot at qaddr per start
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 8'h00;
      div_cnt_reg   <= 8'h00;
      bit_reg       <= 4'h0;
      half_reg      <= 1'b0;
      tx_reg        <= {NBITS{1'b0}};
      rx_reg        <= {NBITS{1'b0}};
      xfer_addr_reg <= {QAW{1'b0}};
      sck_reg       <= 1'b0;
      mosi_reg      <= 1'b0;
      cs_out_reg    <= 5'h00;
    end else begin
      div_cnt_reg <= tick ? div_reg : div_cnt_reg - 8'h01;
      case (state_reg)
        ST_IDLE: begin
          sck_reg    <= cpol;
          cs_out_reg <= ~cs_pol_reg;
          if (reg_wr && reg_addr == `QSM_A_START) begin
            xfer_addr_reg <= qaddr_reg;
            tx_reg        <= queue_mem[qaddr_reg];
            cs_out_reg    <= ~cs_pol_reg ^ (5'h01 << cs_sel_reg);
            cnt_reg       <= delay_reg;
            bit_reg       <= 4'h0;
            half_reg      <= 1'b0;
            div_cnt_reg   <= div_reg;
            state_reg     <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          // select is already active; hold off the clock for delay_reg + 1 cycles
          if (cnt_reg == 8'h00) begin
            mosi_reg  <= tx_bit;
            if (!cpha) begin
              tx_reg <= tx_shift;
            end
            div_cnt_reg <= div_reg;
            state_reg   <= ST_SHIFT;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sck_reg  <= sck_next;
            half_reg <= ~half_reg;
            if (samp_edge) begin
              rx_reg <= rx_shift;
            end else if (half_reg || cpha) begin
              mosi_reg <= tx_bit;
              tx_reg   <= tx_shift;
            end
            if (half_reg) begin
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == NBITS - 1) begin
                state_reg <= ST_TAIL;
              end
            end
          end
        end
        ST_TAIL: begin
          sck_reg <= cpol;
          if (tick) begin
            cs_out_reg <= ~cs_pol_reg;
            state_reg  <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // qsm_master

// file: test/qsm_master_assertions.sv
// qsm_master_assertions.sv: pin-level checks of the queued serial master
// assumes binding to qsm_master; settings are tracked by watching register writes
`timescale 1ns/10ps
`include "qsm_defines.vh"
module qsm_master_assertions (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   reset_n,
  // register port
  input wire logic [`QSM_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  // pins
  input wire logic [`QSM_NPIN-1:0]   pin_out,
  input wire logic [`QSM_NPIN-1:0]   pin_oe,
  input wire logic [`QSM_NPIN-1:0]   pin_pull_en
);
  logic [3:0] ctrl_q;
  logic [4:0] pol_q;
  // the design's idle select level follows a polarity write one cycle late
  logic [4:0] pol_d;
  logic [7:0] dly_q;
  logic [7:0] pen_q;
  logic [4:0] sel_v;
  logic       sel;
  always_ff @(posedge sys_clk) begin
    pol_d <= pol_q;
    if (!reset_n) begin
      ctrl_q <= `QSM_CTRL_RST;
      pol_q  <= `QSM_CS_POL_RST;
      dly_q  <= `QSM_DELAY_RST;
      pen_q  <= `QSM_PIN_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `QSM_A_CTRL:   ctrl_q <= reg_wdata[3:0];
        `QSM_A_CS_POL: pol_q <= reg_wdata[4:0];
        `QSM_A_DELAY:  dly_q <= reg_wdata[7:0];
        `QSM_A_PIN_EN: pen_q <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end
  // a select counts only while its pin is in function mode
  assign sel_v = pen_q[4:0] & ~(pin_out[4:0] ^ pol_d);
  assign sel   = |sel_v;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_quiet;
    $stable(pin_out[`QSM_PIN_SCK]) [*3];
  endsequence
  sequence s_start;
    $rose(sel) && dly_q >= 8'h02;
  endsequence
  property p_pull_off;
    (pin_oe & pin_pull_en) == 8'h00;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull left on driven pin");
  property p_reset_gpi;
    $rose(reset_n) |-> pin_oe == 8'h00 && pin_pull_en == 8'hFF;
  endproperty
  a_reset_gpi: assert property (p_reset_gpi) else $error("pins not inputs after reset");
  property p_one_sel;
    $onehot0(sel_v);
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("several selects active");
  property p_sel_hold;
    $rose(sel) |-> sel [*8];
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select dropped early");
  property p_delay;
    s_start |-> s_quiet;
  endproperty
  a_delay: assert property (p_delay) else $error("clock edge too soon after select");
  property p_sck_framed;
    pen_q[5] && !$past(reg_wr, 2) && $changed(pin_out[5]) |-> sel || $past(sel);
  endproperty
  a_sck_framed: assert property (p_sck_framed) else $error("clock edge outside frame");
  property p_sck_idle;
    pen_q[5] && !sel && !$past(sel) && !$past(reg_wr)
      |-> pin_out[5] == ctrl_q[`QSM_CTRL_CPOL];
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("idle clock level wrong");
  property p_mosi_edge;
    // the first bit is set up before any clock edge, so only moves beside an edge count
    sel && $past(sel) && $changed(pin_out[6]) && $changed(pin_out[5])
      |-> (ctrl_q[`QSM_CTRL_SAMP_FALL] ? $rose(pin_out[5]) : $fell(pin_out[5]));
  endproperty
  a_mosi_edge: assert property (p_mosi_edge) else $error("data moved on wrong edge");
endmodule // qsm_master_assertions

// file: test/qsm_periph_model.sv
// qsm_periph_model.sv: behavioural serial peripheral on the far side
// assumes the bench decodes its select level and gives it edge and bit order
`timescale 1ns/10ps
module qsm_periph_model (
  // link
  input  wire logic       sel,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // setup
  input  wire logic       samp_fall,
  input  wire logic       lsb,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh;
  logic       seen;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
    seen = 1'b0;
  end
  always @(posedge sel) begin
    sh = tx_byte;
    seen = 1'b0;
    miso = lsb ? tx_byte[0] : tx_byte[7];
  end
  // released line must not keep showing the last bit
  always @(negedge sel) miso = ~miso;
  always @(sck) begin
    if (sel && (sck ^ samp_fall)) begin
      rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      seen = 1'b1;
    end else if (sel && seen) begin
      sh = lsb ? sh >> 1 : sh << 1;
      miso = lsb ? sh[0] : sh[7];
    end
  end
endmodule // qsm_periph_model

// file: test/qsm_master_tb.sv
// qsm_master_tb.sv: self-checking bench of the queued serial master
// assumes the peripheral model and the checker file compiled before it
`timescale 1ns/10ps
`include "qsm_defines.vh"
module qsm_master_tb;
  logic        sys_clk, reset_n, reg_wr, reg_rd, samp_fall, lsb, pol;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, rd_v;
  logic [7:0]  pin_in, p_tx;
  logic [2:0]  cs;
  wire  [31:0] reg_rdata;
  wire  [7:0]  pin_out, pin_oe, pin_pull_en, p_rx;
  wire         miso, p_sel;
  int          n_errors, cmp_count, cyc;
  qsm_master u_qsm_master (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en));
  qsm_periph_model u_qsm_periph_model (.sel(p_sel), .sck(pin_in[5]), .mosi(pin_in[6]),
    .miso(miso), .samp_fall(samp_fall), .lsb(lsb), .tx_byte(p_tx), .rx_byte(p_rx));
  // selects 0..3 pull up, select 4 pulls down
  always_comb begin
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : (pin_pull_en[i] && i < 4);
    if (!pin_oe[7]) pin_in[7] = miso;
  end
  assign p_sel = (pin_in[cs] == pol);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic t_reset();
    chk(pin_oe, 8'h00);
    chk(pin_pull_en, 8'hFF);
    rd(4'hF);
    chk(rd_v, 32'h0);
    rd(`QSM_A_DELAY);
    chk(rd_v, 32'h01);
    rd(`QSM_A_DIV);
    chk(rd_v, 32'h04);
  endtask
  task automatic t_gpio();
    wr(`QSM_A_GPIO_OE, 32'h0F);
    wr(`QSM_A_GPIO_OUT, 32'h05);
    repeat (4) @(posedge sys_clk);
    #1 chk(pin_oe, 8'h0F);
    chk(pin_pull_en, 8'hF0);
    rd(`QSM_A_GPIO_IN);
    chk(rd_v[4:0], 5'h05);
    wr(`QSM_A_GPIO_OE, 32'h00);
  endtask
  task automatic t_xfer(input logic [3:0] c, input logic [2:0] s, input logic pl,
                        input logic [7:0] tx, input logic [7:0] ptx);
    logic [4:0] pv;
    pv = pl ? (5'h01 << s) : ~(5'h01 << s);
    cs = s;
    pol = pl;
    samp_fall = c[3];
    lsb = c[2];
    p_tx = ptx;
    wr(`QSM_A_CTRL, {28'h0, c});
    wr(`QSM_A_CS_POL, {27'h0, pv});
    wr(`QSM_A_CS_SEL, {29'h0, s});
    wr(`QSM_A_DELAY, 32'h03);
    wr(`QSM_A_PIN_EN, 32'hFF);
    wr(`QSM_A_QADDR, {29'h0, s});
    wr(`QSM_A_QDATA, {24'h0, tx});
    wr(`QSM_A_START, 32'h01);
    #1 chk(pin_out[s], pl);
    for (int k = 0; k < 500; k++) begin
      rd(`QSM_A_STATUS);
      if (rd_v[0] === 1'b0) break;
    end
    chk(rd_v[0], 1'b0);
    chk(pin_out[s], {~pl});
    chk(p_rx, tx);
    rd(`QSM_A_QDATA);
    chk(rd_v[7:0], ptx);
  endtask
  initial begin
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cs = 3'd0;
    pol = 1'b0;
    samp_fall = 1'b0;
    lsb = 1'b0;
    p_tx = 8'h00;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1 t_reset();
    t_gpio();
    // four clock modes, then lsb first; each on its own select and polarity
    t_xfer(4'h0, 3'd0, 1'b0, 8'hA5, 8'h3C);
    t_xfer(4'hA, 3'd1, 1'b1, 8'h81, 8'h7E);
    t_xfer(4'h9, 3'd2, 1'b0, 8'h4D, 8'hB2);
    t_xfer(4'h3, 3'd3, 1'b1, 8'hF0, 8'h0F);
    // last one with a faster serial clock
    wr(`QSM_A_DIV, 32'h02);
    t_xfer(4'h4, 3'd4, 1'b0, 8'h12, 8'hC8);
    summarize();
  end
endmodule // qsm_master_tb
bind qsm_master qsm_master_assertions u_qsm_master_assertions (.sys_clk(sys_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en));
